// ### core/tcc_pkg.sv
package tcc_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0]  OFS_TIMER_CONFIG   = 8'h8C;
    localparam logic [7:0]  OFS_TIMER_VIEW     = 8'h90;
    localparam logic [7:0]  OFS_HALFWORD_ORDER = 8'h98;
    localparam logic [7:0]  OFS_TICK_COUNTER   = 8'h9C;
    localparam logic [7:0]  OFS_DISCARD_TALLY  = 8'hA0;
    // ************************************************************
    // fields and reset values
    // ************************************************************
    localparam int          TIMER_RUN_BIT      = 29;
    localparam logic [15:0] PRELOAD_RESET      = 16'hFFFF;
    localparam logic [15:0] COUNT_RESET        = 16'hFFFF;
    localparam logic [31:0] ORDER_RESET        = 32'h00000000;
    localparam logic [31:0] ORDER_SWAPPED      = 32'hFFFFFFFF;
    localparam logic [31:0] TALLY_RESET        = 32'h00000000;
    localparam logic [31:0] TALLY_HALFWAY      = 32'h80000000;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int          CLK_MHZ            = 250;
    localparam int          TICK_MHZ           = 25;
    localparam int          TICK_DIV           = CLK_MHZ / TICK_MHZ;
    localparam int          GPT_TICK_DIV       = 250;
    localparam int          CLEAR_DELAY_NS     = 160;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } tcc_req_s;
endpackage : tcc_pkg

// ### core/tcc_regs.sv
`timescale 1ns/1ns
// How it works
// - writing one to the run bit starts the timer and writing zero halts it.
// - a one-to-zero change of the run bit forces the preload to FFFFh.
// - the preload sits in bits 15:0, resets to FFFFh and is the start value.
// - a running timer raises a periodic interrupt set by the preload.
// - a read-only field shows the live timer count, resetting to FFFFh.
// - in 32-bit mode ordering is ignored and bus halves map straight.
// - in 16-bit mode with ordering not all ones, A1 set reaches the high word.
// - in 16-bit mode with ordering all ones, A1 set reaches the low word.
// - fifo data order to the network is always low word first.
// - a 32-bit counter starts at zero and counts every 25MHz cycle, wrapping.
// - in 16-bit mode the first halfword read of the counter latches it all.
// - after reset the counter may need up to 160ns to read as cleared.
// - the counter runs in every power state.
// - a 32-bit tally, reset to zero, counts each discarded receive frame.
// - any read of the tally returns its count and then clears it.
// - an event is raised when the tally steps into 80000000h.
module tcc_regs
    import tcc_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        BUS16,
    input  wire logic        RD,
    input  wire logic        WR,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        FRAME_DROP,
    output logic      [31:0] RDATA,
    output logic             TIMER_IRQ,
    output logic             TALLY_IRQ
);
    // ************************************************************
    // request decode
    // ************************************************************
    tcc_req_s    req;
    logic        swap_q;
    logic        swap_d;
    logic [7:0]  word_addr;
    logic        high_sel;
    logic [15:0] half_in;
    logic        bus16_meta_q;
    logic        bus16_q;

    // strap pin, resynchronised before any use
    always_ff @(posedge CLK) begin
        bus16_meta_q <= BUS16;
        bus16_q      <= bus16_meta_q;
    end

    assign req       = '{rd: RD, wr: WR, addr: ADDR, wdata: WDATA};
    assign word_addr = {req.addr[7:2], 2'b00};
    // A1 picks the half; all-ones order flips it
    assign high_sel  = req.addr[1] ^ swap_q;
    assign half_in   = req.wdata[15:0];

    function automatic logic [31:0] merge16(input logic [31:0] old, input logic hi,
                                            input logic [15:0] v);
        merge16 = hi ? {v, old[15:0]} : {old[31:16], v};
    endfunction : merge16

    function automatic logic [31:0] wr_value(input logic [31:0] old);
        wr_value = bus16_q ? merge16(old, high_sel, half_in) : req.wdata;
    endfunction : wr_value

    wire hit_cfg   = word_addr == OFS_TIMER_CONFIG;
    wire hit_view  = word_addr == OFS_TIMER_VIEW;
    wire hit_order = word_addr == OFS_HALFWORD_ORDER;
    wire hit_tick  = word_addr == OFS_TICK_COUNTER;
    wire hit_tally = word_addr == OFS_DISCARD_TALLY;

    // ************************************************************
    // host halfword order
    // ************************************************************
    logic [31:0] order_q;
    logic [31:0] order_d;
    assign order_d = (req.wr && hit_order) ? wr_value(order_q) : order_q;
    assign swap_d  = (order_d == ORDER_SWAPPED);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            order_q <= ORDER_RESET;
            swap_q  <= 1'b0;
        end else begin
            order_q <= order_d;
            swap_q  <= swap_d;
        end
    end

    // ************************************************************
    // general purpose timer
    // ************************************************************
    logic [31:0] cfg_q;
    logic [31:0] cfg_wr;
    logic        run_q;
    logic        run_d;
    logic [15:0] preload_q;
    logic [15:0] preload_d;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [7:0]  gpt_div_q;
    logic        gpt_tick;
    logic        wrap;

    assign cfg_q     = {2'b00, run_q, 13'h0000, preload_q};
    assign cfg_wr    = wr_value(cfg_q);
    assign run_d     = (req.wr && hit_cfg) ? cfg_wr[TIMER_RUN_BIT] : run_q;
    assign preload_d = (run_q && !run_d) ? PRELOAD_RESET :
                       (req.wr && hit_cfg) ? cfg_wr[15:0] : preload_q;
    assign gpt_tick  = (gpt_div_q == 8'(GPT_TICK_DIV - 1));
    assign wrap      = run_q && gpt_tick && (count_q == 16'h0000);
    assign count_d   = !run_q ? preload_d :
                       !gpt_tick ? count_q :
                       wrap ? preload_q : 16'(count_q - 16'h0001);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            run_q     <= 1'b0;
            preload_q <= PRELOAD_RESET;
            count_q   <= COUNT_RESET;
            gpt_div_q <= 8'h00;
            TIMER_IRQ <= 1'b0;
        end else begin
            run_q     <= run_d;
            preload_q <= preload_d;
            count_q   <= count_d;
            gpt_div_q <= gpt_tick ? 8'h00 : 8'(gpt_div_q + 8'h01);
            TIMER_IRQ <= wrap;
        end
    end

    // ************************************************************
    // free running 25MHz counter
    // ************************************************************
    logic [31:0] tick_q;
    logic [3:0]  tick_div_q;
    logic [31:0] tick_latch_q;
    logic        tick_held_q;
    logic        tick_en;
    assign tick_en = (tick_div_q == 4'(TICK_DIV - 1));

    // runs in every power state; cleared the edge after reset, well inside 160ns
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            tick_q       <= 32'h00000000;
            tick_div_q   <= 4'h0;
            tick_latch_q <= 32'h00000000;
            tick_held_q  <= 1'b0;
        end else begin
            tick_div_q <= tick_en ? 4'h0 : 4'(tick_div_q + 4'h1);
            if (tick_en) begin
                tick_q <= 32'(tick_q + 32'h00000001);
            end
            if (req.rd && hit_tick && bus16_q) begin
                tick_held_q <= !tick_held_q;
                if (!tick_held_q) begin
                    tick_latch_q <= tick_q;
                end
            end
        end
    end

    // ************************************************************
    // discarded frame tally
    // ************************************************************
    logic [31:0] tally_q;
    logic [31:0] tally_d;
    logic        tally_rd;
    assign tally_rd = req.rd && hit_tally;
    // a drop in the clearing cycle is kept
    assign tally_d  = tally_rd ? {31'h0, FRAME_DROP} :
                      FRAME_DROP ? 32'(tally_q + 32'h00000001) : tally_q;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            tally_q   <= TALLY_RESET;
            TALLY_IRQ <= 1'b0;
        end else begin
            tally_q   <= tally_d;
            TALLY_IRQ <= FRAME_DROP && !tally_rd && (tally_d == TALLY_HALFWAY);
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    logic [31:0] word_rd;
    logic [31:0] tick_rd;
    assign tick_rd = (bus16_q && tick_held_q) ? tick_latch_q : tick_q;
    assign word_rd = hit_cfg   ? cfg_q :
                     hit_view  ? {16'h0000, count_q} :
                     hit_order ? order_q :
                     hit_tick  ? tick_rd :
                     hit_tally ? tally_q : 32'h00000000;

    // fifo word order is fixed low first; only host-side halves are steered
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            RDATA <= 32'h00000000;
        end else if (req.rd) begin
            RDATA <= !bus16_q ? word_rd :
                     {16'h0000, high_sel ? word_rd[31:16] : word_rd[15:0]};
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    run_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $fell(run_q) |-> preload_q == PRELOAD_RESET)
        else $error("preload not forced on halt");

    tally_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && hit_tally && !FRAME_DROP) |=> tally_q == 32'h00000000)
        else $error("tally not cleared by read");

    tally_count_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (FRAME_DROP && !tally_rd) |=> tally_q == 32'($past(tally_q) + 1))
        else $error("tally missed a drop");

    tick_step_a: assert property (@(posedge CLK) disable iff (!RST_N)
        tick_en |=> tick_q == 32'($past(tick_q) + 1))
        else $error("free counter did not step");

    halt_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !run_q |=> count_q == preload_q)
        else $error("halted timer not at preload");

    wrap_irq_a: assert property (@(posedge CLK) disable iff (!RST_N)
        wrap |=> TIMER_IRQ && count_q == $past(preload_q))
        else $error("timer wrap not flagged");

    view_live_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && hit_view && !bus16_q) |=> RDATA == {16'h0000, $past(count_q)})
        else $error("view not live count");

    swap_map_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && bus16_q && hit_order && swap_q && !ADDR[1]) |=> RDATA[15:0] == 16'hFFFF)
        else $error("swapped halfword wrong");

    order_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && hit_order && !bus16_q) |=> order_q == $past(WDATA))
        else $error("order word not written");

    order_high_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && hit_order && bus16_q && !swap_q && ADDR[1])
        |=> order_q[31:16] == $past(WDATA[15:0]))
        else $error("order high half not written");

    order_low_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && hit_order && bus16_q && !swap_q && !ADDR[1])
        |=> order_q[15:0] == $past(WDATA[15:0]))
        else $error("order low half not written");

    swap_flag_a: assert property (@(posedge CLK) disable iff (!RST_N)
        swap_q == (order_q == ORDER_SWAPPED))
        else $error("swap flag out of step");

    rd_word_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && hit_cfg && !bus16_q) |=> RDATA == $past(cfg_q))
        else $error("config word read wrong");

    rd_high_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && bus16_q && hit_cfg && !swap_q && ADDR[1])
        |=> RDATA == {16'h0000, $past(cfg_q[31:16])})
        else $error("high half read wrong");

    rd_low_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && bus16_q && hit_cfg && !swap_q && !ADDR[1])
        |=> RDATA == {16'h0000, $past(cfg_q[15:0])})
        else $error("low half read wrong");

    rd_upper_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && bus16_q) |=> RDATA[31:16] == 16'h0000)
        else $error("upper lanes not zero");

    run_start_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && hit_cfg && !bus16_q && WDATA[TIMER_RUN_BIT]) |=> run_q)
        else $error("timer did not start");

    run_stop_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && hit_cfg && !bus16_q && !WDATA[TIMER_RUN_BIT]) |=> !run_q)
        else $error("timer did not halt");

    preload_wr_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && hit_cfg && !bus16_q && !(run_q && !WDATA[TIMER_RUN_BIT]))
        |=> preload_q == $past(WDATA[15:0]))
        else $error("preload not written");

    count_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (run_q && !gpt_tick) |=> count_q == $past(count_q))
        else $error("timer moved between ticks");

    count_step_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (run_q && gpt_tick && count_q != 16'h0000)
        |=> count_q == 16'($past(count_q) - 16'h0001))
        else $error("timer did not step down");

    irq_cause_a: assert property (@(posedge CLK) disable iff (!RST_N)
        TIMER_IRQ |-> $past(wrap))
        else $error("timer irq without wrap");

    irq_pulse_a: assert property (@(posedge CLK) disable iff (!RST_N)
        TIMER_IRQ |=> !TIMER_IRQ)
        else $error("timer irq longer than a cycle");

    halt_quiet_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !run_q |=> !TIMER_IRQ)
        else $error("halted timer raised irq");

    tick_div_a: assert property (@(posedge CLK) disable iff (!RST_N)
        tick_div_q < 4'(TICK_DIV))
        else $error("tick divider out of range");

    tick_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !tick_en |=> tick_q == $past(tick_q))
        else $error("free counter moved off tick");

    tick_latch_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && hit_tick && bus16_q && !tick_held_q)
        |=> tick_held_q && tick_latch_q == $past(tick_q))
        else $error("first half read did not latch");

    tick_second_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && hit_tick && bus16_q && tick_held_q)
        |=> !tick_held_q && RDATA == {16'h0000, $past(high_sel) ?
            $past(tick_latch_q[31:16]) : $past(tick_latch_q[15:0])})
        else $error("second half read not latched");

    reset_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(RST_N) |-> tick_q == 32'h00000000 && tally_q == TALLY_RESET)
        else $error("counters not cleared by reset");

    tally_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (!FRAME_DROP && !tally_rd) |=> tally_q == $past(tally_q))
        else $error("tally moved without drop");

    tally_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && hit_tally && !bus16_q) |=> RDATA == $past(tally_q))
        else $error("tally read wrong");

    tally_irq_a: assert property (@(posedge CLK) disable iff (!RST_N)
        TALLY_IRQ |-> tally_q == TALLY_HALFWAY)
        else $error("tally irq off halfway");

    rd_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !RD |=> RDATA == $past(RDATA))
        else $error("read data not held");

    rd_unmapped_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && !bus16_q && !(hit_cfg || hit_view || hit_order || hit_tick || hit_tally))
        |=> RDATA == 32'h00000000)
        else $error("unmapped read not zero");
endmodule : tcc_regs

// ### bench/tcc_host.sv
`timescale 1ns/1ns
// ************************************************************
// host cpu bus model
// ************************************************************
module tcc_host
    import tcc_pkg::*;
(
    input  wire logic        CLK,
    output logic             RD,
    output logic             WR,
    output logic      [7:0]  ADDR,
    output logic      [31:0] WDATA,
    input  wire logic [31:0] RDATA
);
    initial begin
        RD    = 1'b0;
        WR    = 1'b0;
        ADDR  = 8'h00;
        WDATA = 32'h00000000;
    end

    // released lines show the inverse, never the last value
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        WR    <= 1'b1;
        ADDR  <= a;
        WDATA <= d;
        @(posedge CLK);
        WR    <= 1'b0;
        ADDR  <= ~a;
        WDATA <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CLK);
        RD   <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD   <= 1'b0;
        ADDR <= ~a;
        @(posedge CLK);
        #1 d = RDATA;
    endtask : rd
endmodule : tcc_host

// ### bench/tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
// ************************************************************
// testbench top
// ************************************************************
module tb_top;
    import tcc_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        bus16;
    logic        frame_drop;
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        timer_irq;
    logic        tally_irq;
    logic [31:0] d;
    logic [31:0] e;
    int          n;
    int          miscompares = 0;
    int          compares = 0;

    tcc_host u_host (.CLK(clk), .RD(rd), .WR(wr), .ADDR(addr), .WDATA(wdata), .RDATA(rdata));
    tcc_regs u_dut (.CLK(clk), .RST_N(rst_n), .BUS16(bus16), .RD(rd), .WR(wr), .ADDR(addr),
        .WDATA(wdata), .FRAME_DROP(frame_drop), .RDATA(rdata), .TIMER_IRQ(timer_irq),
        .TALLY_IRQ(tally_irq));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic do_reset(input logic b16);
        @(posedge clk);
        bus16 <= b16;
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset

    task automatic wait_irq();
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (timer_irq !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            miscompares++;
            stop_test();
        end
    endtask : wait_irq

    task automatic check_resets();
        u_host.rd(OFS_TICK_COUNTER, d);
        `CHK("tick_early", 1'b1, d < 32'h4)
        u_host.rd(OFS_TIMER_CONFIG, e);
        `CHK("cfg", 32'h0000FFFF, e)
        u_host.rd(OFS_TIMER_VIEW, e);
        `CHK("view", 32'h0000FFFF, e)
        u_host.rd(OFS_DISCARD_TALLY, e);
        `CHK("tally", TALLY_RESET, e)
        u_host.rd(8'h94, e);
        `CHK("unmapped", 32'h00000000, e)
        u_host.wr(OFS_HALFWORD_ORDER, ORDER_SWAPPED);
        u_host.rd(OFS_TIMER_CONFIG, e);
        `CHK("cfg32", 32'h0000FFFF, e)
        repeat (94) @(posedge clk);
        u_host.rd(OFS_TICK_COUNTER, e);
        `CHK("tick_rate", 1'b1, (e - d) inside {32'hA, 32'hB})
    endtask : check_resets

    task automatic check_timer();
        u_host.wr(OFS_TIMER_CONFIG, 32'h20000002);
        wait_irq();
        wait_irq();
        `CHK("period", 3 * GPT_TICK_DIV, n)
        u_host.wr(OFS_TIMER_CONFIG, 32'h00000002);
        u_host.rd(OFS_TIMER_CONFIG, e);
        `CHK("halt_cfg", 32'h0000FFFF, e)
        u_host.rd(OFS_TIMER_VIEW, e);
        `CHK("halt_view", 32'h0000FFFF, e)
    endtask : check_timer

    task automatic check_tally();
        repeat (3) begin
            @(posedge clk);
            frame_drop <= 1'b1;
            @(posedge clk);
            frame_drop <= 1'b0;
        end
        u_host.rd(OFS_DISCARD_TALLY, e);
        `CHK("tally3", 32'h00000003, e)
        `CHK("tally_irq", 1'b0, tally_irq)
        u_host.rd(OFS_DISCARD_TALLY, e);
        `CHK("tally_clr", 32'h00000000, e)
    endtask : check_tally

    task automatic check_order();
        do_reset(1'b1);
        u_host.rd(8'h8E, e);
        `CHK("hi_plain", 32'h00000000, e)
        u_host.rd(8'h8C, e);
        `CHK("lo_plain", 32'h0000FFFF, e)
        u_host.wr(8'h98, 32'h0000FFFF);
        u_host.wr(8'h9A, 32'h0000FFFF);
        u_host.rd(8'h8C, e);
        `CHK("hi_swap", 32'h00000000, e)
        u_host.rd(8'h8E, e);
        `CHK("lo_swap", 32'h0000FFFF, e)
        u_host.rd(8'h9E, d);
        repeat (20) @(posedge clk);
        u_host.rd(8'h9E, e);
        `CHK("tick_latched", d, e)
    endtask : check_order

    initial begin
        rst_n      = 1'b0;
        bus16      = 1'b0;
        frame_drop = 1'b0;
        do_reset(1'b0);
        check_resets();
        check_timer();
        check_tally();
        check_order();
        stop_test();
    end
endmodule : tb_top
